// ==== core/usb_device_status_frame_addr.sv ====
// Status, frame tracking and addressing logic of a full-speed device port
//
// Functional notes
// - Activity in suspend: wake flag, drop low-power, notify
// - Event flags clear on written zero only
// - Suspend request after 3 ms without traffic
// - Idle check armed by reset, off in suspend
// - Bus reset sets flag, resets protocol engine
// - No packets until reset flag cleared
// - Bus reset clears address and endpoint registers
// - Frame start sets flag, updates frame register
// - Missed frame start sets missed flag
// - Three misses without traffic request suspend
// - Missed flag set even when unlocked
// - Direction bit from interrupting endpoint's completions
// - Priority: iso/double-buffered first, lowest index
// - Frame register shows received D+ D- levels
// - Lock after two frame starts, cleared by reset/suspend
// - Two-bit lost count, cleared by frame start
// - Eleven-bit frame number captured at frame start
// - Function disabled means no transactions
// - Token address and endpoint must both match
// - Table base 8-byte aligned, low bits zero
// - Fetch table entry at each addressed transaction
// - One interrupt line from masked pending flags
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module usb_device_status_frame_addr
#(
   parameter int IDLE_CYCLES = usb_status_pkg::IDLE_CYC,  // Idle time to suspend
   parameter int FRAME_CYCLES = usb_status_pkg::FRAME_CYC // Frame period
) (
   input wire logic core_clk,            // Core clock
   input wire logic resetn,              // Async reset, active low
   input wire logic [7:0] regAddr,       // Register byte address
   input wire logic [15:0] regWdata,     // Write data
   input wire logic regWr,               // Write strobe
   input wire logic regRd,               // Read strobe
   output logic [15:0] regRdata,         // Read data, cycle after strobe
   input wire logic dpPin,               // Received D+ level
   input wire logic dmPin,               // Received D- level
   input wire logic busActivity,         // Any bus traffic seen, pulse
   input wire logic busResetDet,         // Bus reset signalling, level
   input wire logic sofValid,            // Frame start packet received
   input wire logic [10:0] sofNumber,    // Frame number of that packet
   input wire logic resumeDone,          // Resume sequence finished
   input wire logic tokValid,            // Token received
   input wire logic [6:0] tokAddr,       // Token device address
   input wire logic [3:0] tokEp,         // Token endpoint number
   input wire logic [usb_status_pkg::NUM_EP*4-1:0] epAddrField, // Endpoint address fields
   input wire logic [usb_status_pkg::NUM_EP-1:0] epTxComplete, // Per-endpoint tx done
   input wire logic [usb_status_pkg::NUM_EP-1:0] epRxComplete, // Per-endpoint rx done
   input wire logic [usb_status_pkg::NUM_EP-1:0] epHighPrio, // Iso or double-buffered
   output logic irqOut,                  // Interrupt request
   output logic wakeupLine,              // Wake notification to chip
   output logic protoReset,              // Protocol engine reset pulse
   output logic epRegClear,              // Endpoint register clear pulse
   output logic xferEnable,              // Packet rx/tx allowed
   output logic txnAccept,               // Token accepted pulse
   output logic [2:0] txnEpIdx,          // Accepted endpoint register
   output logic btFetch,                 // Table entry fetch pulse
   output logic [15:0] btFetchAddr       // Table entry address
);
   import usb_status_pkg::*;

   // ----------------------------------------------------------------
   // Reset and pin synchronisers
   // ----------------------------------------------------------------
   logic rstMeta_q, rstSyncN_q;
   logic [1:0] lineMeta_q, lineSync_q;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta_q <= 1'b0;
         rstSyncN_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSyncN_q <= rstMeta_q;
      end
   end

   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         lineMeta_q <= 2'h0;
         lineSync_q <= 2'h0;
      end else begin
         lineMeta_q <= {dpPin, dmPin};
         lineSync_q <= lineMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // Software state
   // ----------------------------------------------------------------
   logic [15:0] control_q;
   logic [7:0] devAddr_q;
   logic [12:0] btBase_q;
   logic busResetDly_q;
   logic resetRise, suspended;
   logic wrCtl, wrIrq, wrDev, wrBt;

   assign resetRise = busResetDet && !busResetDly_q;
   assign suspended = control_q[BIT_FORCE_SUSPEND];
   assign wrCtl = regWr && (regAddr == OFS_CONTROL);
   assign wrIrq = regWr && (regAddr == OFS_IRQ_EVENT);
   assign wrDev = regWr && (regAddr == OFS_DEVICE_ADDRESS);
   assign wrBt = regWr && (regAddr == OFS_BUFFER_TABLE);
   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         busResetDly_q <= 1'b0;
      end else begin
         busResetDly_q <= busResetDet;
      end
   end

   // Wake clears low-power in the same edge; it beats a software set
   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         control_q <= RST_CONTROL;
      end else begin
         if (wrCtl) begin
            control_q <= regWdata;
         end
         if (suspended && busActivity) begin
            control_q[BIT_LOW_POWER] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         devAddr_q <= RST_DEVICE_ADDRESS;
      end else if (resetRise) begin
         devAddr_q <= RST_DEVICE_ADDRESS;
      end else if (wrDev) begin
         devAddr_q <= regWdata[7:0];
      end
   end

   // Only bits 15:3 are stored, so the base is always 8-byte aligned
   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         btBase_q <= RST_BUFFER_TABLE;
      end else if (wrBt) begin
         btBase_q <= regWdata[15:3];
      end
   end

   // ----------------------------------------------------------------
   // Idle, frame and lock tracking
   // ----------------------------------------------------------------
   logic [31:0] idleCnt_q, frameCnt_q;
   logic armed_q, locked_q, missEvent, idleHit, missHit;
   logic [1:0] missNoTraffic_q, lost_q, sofRun_q;
   logic [10:0] frameNum_q;
   assign missEvent = !suspended && (frameCnt_q == 32'(FRAME_CYCLES - 1)) && !sofValid;
   assign idleHit = armed_q && !busActivity && (idleCnt_q == 32'(IDLE_CYCLES - 1));
   assign missHit = armed_q && missEvent && !busActivity
                    && (missNoTraffic_q == MISS_TO_SUSPEND - 2'h1);
   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         idleCnt_q <= 32'h0;
      end else if (busActivity || !armed_q || idleHit) begin
         idleCnt_q <= 32'h0;
      end else begin
         idleCnt_q <= idleCnt_q + 32'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         armed_q <= 1'b0;
      end else if (busResetDet) begin
         armed_q <= 1'b1;
      end else if (suspended || idleHit || missHit) begin
         armed_q <= 1'b0;
      end else if (resumeDone) begin
         armed_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         frameCnt_q <= 32'h0;
      end else if (sofValid || suspended || missEvent) begin
         frameCnt_q <= 32'h0;
      end else begin
         frameCnt_q <= frameCnt_q + 32'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         missNoTraffic_q <= 2'h0;
      end else if (busActivity || sofValid || missHit) begin
         missNoTraffic_q <= 2'h0;
      end else if (missEvent) begin
         missNoTraffic_q <= missNoTraffic_q + 2'h1;
      end
   end

   // Lost count saturates so a long outage never wraps back to zero
   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         lost_q <= 2'h0;
         frameNum_q <= 11'h000;
      end else if (sofValid) begin
         lost_q <= 2'h0;
         frameNum_q <= sofNumber;
      end else if (missEvent && (lost_q != 2'h3)) begin
         lost_q <= lost_q + 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         sofRun_q <= 2'h0;
         locked_q <= 1'b0;
      end else if (busResetDet || suspended) begin
         sofRun_q <= 2'h0;
         locked_q <= 1'b0;
      end else if (missEvent) begin
         sofRun_q <= 2'h0;
      end else if (sofValid) begin
         if (sofRun_q != SOF_TO_LOCK) begin
            sofRun_q <= sofRun_q + 2'h1;
         end
         if (sofRun_q == SOF_TO_LOCK - 2'h1) begin
            locked_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Event flags: hardware set wins over a software clear
   // ----------------------------------------------------------------
   logic [4:0] evSet, flags_q, flags_d;
   assign evSet = {suspended && busActivity, idleHit || missHit, resetRise,
                   sofValid, missEvent};
   always_comb begin
      flags_d = flags_q;
      if (wrIrq) begin
         flags_d = flags_q & regWdata[BIT_WAKEUP:BIT_MISSED];
      end
      flags_d = flags_d | evSet;
   end

   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         flags_q <= 5'h00;
      end else begin
         flags_q <= flags_d;
      end
   end

   // ----------------------------------------------------------------
   // Interrupting endpoint and direction
   // ----------------------------------------------------------------
   logic [NUM_EP-1:0] epReq, epHi, tokMatch;
   logic [2:0] pickIdx, matchIdx;
   logic pickAny, matchAny, dir_q;
   logic [3:0] intEp_q;
   genvar g;
   generate
      for (g = 0; g < NUM_EP; g++) begin : gEp
         assign epReq[g] = epTxComplete[g] || epRxComplete[g];
         assign epHi[g] = epReq[g] && epHighPrio[g];
         assign tokMatch[g] = (epAddrField[g*4 +: 4] == tokEp);
      end
   endgenerate

   // Descending scan so the lowest index is the final winner
   always_comb begin
      pickIdx = 3'h0;
      pickAny = 1'b0;
      matchIdx = 3'h0;
      matchAny = 1'b0;
      for (int i = NUM_EP - 1; i >= 0; i--) begin
         if (epReq[i] && !(|epHi)) begin
            pickIdx = 3'(i);
            pickAny = 1'b1;
         end
         if (epHi[i]) begin
            pickIdx = 3'(i);
            pickAny = 1'b1;
         end
         if (tokMatch[i]) begin
            matchIdx = 3'(i);
            matchAny = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         intEp_q <= 4'h0;
         dir_q <= 1'b0;
      end else if (pickAny) begin
         intEp_q <= {1'b0, pickIdx};
         dir_q <= epRxComplete[pickIdx];
      end
   end

   // ----------------------------------------------------------------
   // Transactions, bus reset outputs and interrupt
   // ----------------------------------------------------------------
   logic tokOk;
   assign tokOk = tokValid && xferEnable && devAddr_q[BIT_FUNC_ENABLE]
                  && (tokAddr == devAddr_q[6:0]) && matchAny;

   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         txnAccept <= 1'b0;
         btFetch <= 1'b0;
         txnEpIdx <= 3'h0;
         btFetchAddr <= 16'h0000;
      end else begin
         txnAccept <= tokOk;
         btFetch <= tokOk;
         if (tokOk) begin
            txnEpIdx <= matchIdx;
            btFetchAddr <= {btBase_q + {10'h000, matchIdx}, 3'h0};
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         protoReset <= 1'b0;
         epRegClear <= 1'b0;
         xferEnable <= 1'b0;
         wakeupLine <= 1'b0;
         irqOut <= 1'b0;
      end else begin
         protoReset <= resetRise;
         epRegClear <= resetRise;
         xferEnable <= !flags_d[2] && !busResetDet;
         wakeupLine <= flags_d[4];
         irqOut <= (|(flags_d & control_q[BIT_WAKEUP:BIT_MISSED]))
                   || (control_q[BIT_CTR] && pickAny);
      end
   end

   // ----------------------------------------------------------------
   // Read port: unmapped offsets read zero
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         regRdata <= 16'h0000;
      end else if (regRd) begin
         unique case (regAddr)
            OFS_CONTROL: regRdata <= control_q;
            OFS_IRQ_EVENT: regRdata <= {pickAny, 2'h0, flags_q, 3'h0, dir_q, intEp_q};
            OFS_FRAME_NUMBER: regRdata <= {lineSync_q, locked_q, lost_q, frameNum_q};
            OFS_DEVICE_ADDRESS: regRdata <= {8'h00, devAddr_q};
            OFS_BUFFER_TABLE: regRdata <= {btBase_q, 3'h0};
            default: regRdata <= 16'h0000;
         endcase
      end else begin
         regRdata <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_WAKE_SET: assert property (@(posedge core_clk) disable iff (!rstSyncN_q)
      suspended && busActivity |=> flags_q[4] && wakeupLine && !control_q[BIT_LOW_POWER])
      else $error("wake event not flagged");
   AST_FLAG_CLR: assert property (@(posedge core_clk) disable iff (!rstSyncN_q)
      wrIrq && !regWdata[BIT_RESET] && !resetRise |=> !flags_q[2])
      else $error("reset flag not cleared by zero");
   AST_IDLE_SUSPEND_REQUEST_FLAG: assert property (@(posedge core_clk) disable iff (!rstSyncN_q)
      idleHit |=> flags_q[3] && !armed_q)
      else $error("idle suspend not flagged");
   AST_ARM_OFF: assert property (@(posedge core_clk) disable iff (!rstSyncN_q)
      suspended && !busResetDet |=> !armed_q)
      else $error("idle check armed in suspend");
   AST_BUS_RESET: assert property (@(posedge core_clk) disable iff (!rstSyncN_q)
      resetRise |=> flags_q[2] && protoReset && epRegClear && devAddr_q == 8'h00)
      else $error("bus reset not handled");
   AST_NO_XFER: assert property (@(posedge core_clk) disable iff (!rstSyncN_q)
      flags_q[2] |-> !xferEnable ##1 !txnAccept)
      else $error("transfer while reset flagged");
   AST_SOF: assert property (@(posedge core_clk) disable iff (!rstSyncN_q)
      sofValid |=> flags_q[1] && lost_q == 2'h0 && frameNum_q == $past(sofNumber))
      else $error("frame start not captured");
   AST_MISS: assert property (@(posedge core_clk) disable iff (!rstSyncN_q)
      missEvent && !locked_q |=> flags_q[0])
      else $error("missed frame not flagged");
   AST_LOCK: assert property (@(posedge core_clk) disable iff (!rstSyncN_q)
      $rose(locked_q) |-> $past(sofValid) && $past(sofRun_q) == 2'h1)
      else $error("lock without two frame starts");
   AST_FETCH: assert property (@(posedge core_clk) disable iff (!rstSyncN_q)
      tokOk |=> txnAccept && btFetch && btFetchAddr[2:0] == 3'h0)
      else $error("table entry not fetched");
   AST_IRQ: assert property (@(posedge core_clk) disable iff (!rstSyncN_q)
      (|(flags_q & control_q[BIT_WAKEUP:BIT_MISSED])) && !wrIrq && !wrCtl |=> irqOut)
      else $error("masked pending event without interrupt");
endmodule

// ==== core/usb_status_pkg.sv ====
// Constants shared by the status, frame and address logic
package usb_status_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h40;
   localparam logic [7:0] OFS_IRQ_EVENT = 8'h44;
   localparam logic [7:0] OFS_FRAME_NUMBER = 8'h48;
   localparam logic [7:0] OFS_DEVICE_ADDRESS = 8'h4C;
   localparam logic [7:0] OFS_BUFFER_TABLE = 8'h50;
   // ----------------------------------------------------------------
   // Field positions and endpoint count
   // ----------------------------------------------------------------
   localparam int BIT_CTR = 15;
   localparam int BIT_WAKEUP = 12;
   localparam int BIT_SUSPEND = 11;
   localparam int BIT_RESET = 10;
   localparam int BIT_SOF = 9;
   localparam int BIT_MISSED = 8;
   localparam int BIT_DIR = 4;
   localparam int BIT_FORCE_SUSPEND = 3;
   localparam int BIT_LOW_POWER = 2;
   localparam int BIT_FUNC_ENABLE = 7;
   localparam int NUM_EP = 8;
   // ----------------------------------------------------------------
   // Reset values and event thresholds
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_CONTROL = 16'h0000;
   localparam logic [7:0] RST_DEVICE_ADDRESS = 8'h00;
   localparam logic [12:0] RST_BUFFER_TABLE = 13'h0000;
   localparam logic [1:0] MISS_TO_SUSPEND = 2'h3;
   localparam logic [1:0] SOF_TO_LOCK = 2'h2;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int IDLE_MS = 3;
   localparam int FRAME_MS = 1;
   localparam int IDLE_CYC = IDLE_MS * 1000 * CLK_MHZ;
   localparam int FRAME_CYC = FRAME_MS * 1000 * CLK_MHZ;
endpackage

// ==== dv/usb_host_model.sv ====
// Behavioural upstream host: frames, bus reset, tokens, resume and line levels
`timescale 1ns/1ps
module usb_host_model (
   input wire logic clk, // Core clock
   output logic busActivity, // Traffic pulse
   output logic busResetDet, // Reset signalling level
   output logic sofValid, // Frame start pulse
   output logic [10:0] sofNumber, // Frame number
   output logic resumeDone, // Resume finished pulse
   output logic tokValid, // Token pulse
   output logic [6:0] tokAddr, // Token address
   output logic [3:0] tokEp, // Token endpoint
   output logic dpPin, // D+ level
   output logic dmPin // D- level
);
   // ----------------------------------------------------------------
   // Idle bus: D+ pulled up, packet fields scrambled between packets
   // ----------------------------------------------------------------
   initial begin
      busActivity = 1'b0;
      busResetDet = 1'b0;
      sofValid = 1'b0;
      sofNumber = 11'h2AA;
      resumeDone = 1'b0;
      tokValid = 1'b0;
      tokAddr = 7'h55;
      tokEp = 4'hA;
      dpPin = 1'b1;
      dmPin = 1'b0;
   end
   // Packets count as traffic, so each one also pulses the activity line
   task automatic sof(input logic [10:0] n);
      @(posedge clk);
      sofValid <= 1'b1;
      busActivity <= 1'b1;
      sofNumber <= n;
      @(posedge clk);
      sofValid <= 1'b0;
      busActivity <= 1'b0;
      sofNumber <= ~n;
   endtask
   task automatic token(input logic [6:0] a, input logic [3:0] e);
      @(posedge clk);
      tokValid <= 1'b1;
      busActivity <= 1'b1;
      tokAddr <= a;
      tokEp <= e;
      @(posedge clk);
      tokValid <= 1'b0;
      busActivity <= 1'b0;
      tokAddr <= ~a;
      tokEp <= ~e;
   endtask
   task automatic activity();
      @(posedge clk);
      busActivity <= 1'b1;
      dpPin <= 1'b0;
      dmPin <= 1'b1;
      @(posedge clk);
      busActivity <= 1'b0;
      dpPin <= 1'b1;
      dmPin <= 1'b0;
   endtask
   task automatic resume();
      @(posedge clk);
      resumeDone <= 1'b1;
      @(posedge clk);
      resumeDone <= 1'b0;
   endtask
   // Reset signalling holds both lines low
   task automatic setReset(input logic v);
      @(posedge clk);
      busResetDet <= v;
      dpPin <= ~v;
      dmPin <= 1'b0;
   endtask
endmodule

// ==== dv/tb_usb_device_status_frame_addr.sv ====
// Self-checking bench for the status, frame and address block
`timescale 1ns/1ps
module tb_usb_device_status_frame_addr;
   import usb_status_pkg::*;
   logic core_clk, resetn, regWr, regRd, dpPin, dmPin, busActivity, busResetDet, sofValid;
   logic resumeDone, tokValid, irqOut, wakeupLine, protoReset, epRegClear, xferEnable;
   logic txnAccept, btFetch;
   logic [7:0] regAddr;
   logic [15:0] regWdata, regRdata, btFetchAddr;
   logic [10:0] sofNumber;
   logic [6:0] tokAddr;
   logic [3:0] tokEp;
   logic [2:0] txnEpIdx;
   logic [NUM_EP*4-1:0] epAddrField;
   logic [NUM_EP-1:0] epTx, epRx, epHp;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Short idle and frame counts keep the run brief
   usb_device_status_frame_addr #(.IDLE_CYCLES(50), .FRAME_CYCLES(20)) dut (
      .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .dpPin(dpPin), .dmPin(dmPin),
      .busActivity(busActivity), .busResetDet(busResetDet), .sofValid(sofValid),
      .sofNumber(sofNumber), .resumeDone(resumeDone), .tokValid(tokValid),
      .tokAddr(tokAddr), .tokEp(tokEp), .epAddrField(epAddrField), .epTxComplete(epTx),
      .epRxComplete(epRx), .epHighPrio(epHp), .irqOut(irqOut), .wakeupLine(wakeupLine),
      .protoReset(protoReset), .epRegClear(epRegClear), .xferEnable(xferEnable),
      .txnAccept(txnAccept), .txnEpIdx(txnEpIdx), .btFetch(btFetch),
      .btFetchAddr(btFetchAddr));
   usb_host_model host (.clk(core_clk), .busActivity(busActivity),
      .busResetDet(busResetDet), .sofValid(sofValid), .sofNumber(sofNumber),
      .resumeDone(resumeDone), .tokValid(tokValid), .tokAddr(tokAddr), .tokEp(tokEp),
      .dpPin(dpPin), .dmPin(dmPin));
   // ----------------------------------------------------------------
   // Bus and compare helpers
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge core_clk);
      regWr <= 1'b0;
      regWdata <= ~v;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e,
         input string name);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 chk(name, e, regRdata & m);
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_regs();
      rdc(OFS_DEVICE_ADDRESS, 16'hFFFF, 16'h0000, "addr reset");
      rdc(OFS_BUFFER_TABLE, 16'hFFFF, 16'h0000, "table reset");
      wr(OFS_BUFFER_TABLE, 16'hFFFF);
      rdc(OFS_BUFFER_TABLE, 16'hFFFF, 16'hFFF8, "table low");
      wr(OFS_DEVICE_ADDRESS, 16'hFFFF);
      rdc(OFS_DEVICE_ADDRESS, 16'hFFFF, 16'h00FF, "addr rw");
      rdc(OFS_FRAME_NUMBER, 16'hC000, 16'h8000, "lines");
      rdc(8'h60, 16'hFFFF, 16'h0000, "unmapped");
      $display("regs done");
   endtask
   task automatic test_busreset();
      wr(OFS_CONTROL, 16'h0400);
      host.setReset(1'b1);
      @(posedge core_clk);
      #1 chk("reset out", 16'h000D, {12'h0, protoReset, epRegClear, xferEnable, irqOut});
      repeat (4) @(posedge core_clk);
      host.setReset(1'b0);
      rdc(OFS_DEVICE_ADDRESS, 16'hFFFF, 16'h0000, "addr cleared");
      rdc(OFS_BUFFER_TABLE, 16'hFFFF, 16'hFFF8, "table kept");
      wr(OFS_IRQ_EVENT, 16'hFFFF);
      rdc(OFS_IRQ_EVENT, 16'h0400, 16'h0400, "one keeps");
      repeat (20) @(posedge core_clk);
      rdc(OFS_IRQ_EVENT, 16'h0100, 16'h0100, "miss unlocked");
      rdc(OFS_FRAME_NUMBER, 16'h2000, 16'h0000, "not locked");
      wr(OFS_IRQ_EVENT, 16'hFBFF);
      repeat (2) @(posedge core_clk);
      #1 chk("reset done", 16'h0002, {12'h0, protoReset, epRegClear, xferEnable, irqOut});
      rdc(OFS_IRQ_EVENT, 16'h0800, 16'h0800, "miss suspend");
      wr(OFS_CONTROL, 16'h0000);
      $display("bus reset done");
   endtask
   task automatic test_frames();
      wr(OFS_IRQ_EVENT, 16'h0000);
      host.resume();
      host.sof(11'h123);
      host.sof(11'h124);
      rdc(OFS_FRAME_NUMBER, 16'hFFFF, 16'hA124, "frame reg");
      rdc(OFS_IRQ_EVENT, 16'h0200, 16'h0200, "sof flag");
      repeat (38) @(posedge core_clk);
      rdc(OFS_FRAME_NUMBER, 16'h3800, 16'h3000, "lost two");
      repeat (25) @(posedge core_clk);
      rdc(OFS_FRAME_NUMBER, 16'h1800, 16'h1800, "lost three");
      rdc(OFS_IRQ_EVENT, 16'h0900, 16'h0900, "suspend req");
      $display("frames done");
   endtask
   task automatic test_wake();
      wr(OFS_IRQ_EVENT, 16'h0000);
      wr(OFS_CONTROL, 16'h100C);
      repeat (60) @(posedge core_clk);
      rdc(OFS_IRQ_EVENT, 16'h1900, 16'h0000, "idle off");
      host.activity();
      #1 chk("wake out", 16'h0003, {14'h0, wakeupLine, irqOut});
      rdc(OFS_CONTROL, 16'h100C, 16'h1008, "low power");
      rdc(OFS_IRQ_EVENT, 16'h1000, 16'h1000, "wake flag");
      wr(OFS_CONTROL, 16'h1000);
      host.resume();
      wr(OFS_IRQ_EVENT, 16'h0000);
      #1 chk("wake clear", 16'h0000, {14'h0, wakeupLine, irqOut});
      $display("wake done");
   endtask
   task automatic tok(input logic [15:0] da, input logic [6:0] a, input logic [3:0] e,
         input logic [15:0] exp, input logic [15:0] fa);
      wr(OFS_DEVICE_ADDRESS, da);
      host.token(a, e);
      #1 chk("token", exp, {txnAccept, btFetch, xferEnable, 10'h0, txnAccept ? txnEpIdx : 3'h0});
      if (exp[15]) begin
         chk("fetch addr", fa, btFetchAddr);
      end
   endtask
   task automatic test_tokens();
      wr(OFS_BUFFER_TABLE, 16'h0100);
      tok(16'h0085, 7'h05, 4'h3, 16'hE003, 16'h0118);
      tok(16'h0085, 7'h06, 4'h3, 16'h2000, 16'h0000);
      tok(16'h0085, 7'h05, 4'h9, 16'h2000, 16'h0000);
      tok(16'h0005, 7'h05, 4'h3, 16'h2000, 16'h0000);
      tok(16'h0085, 7'h05, 4'h7, 16'hE007, 16'h0138);
      tok(16'h0080, 7'h00, 4'h0, 16'hE000, 16'h0100);
      epAddrField <= 32'h01234567;
      tok(16'h0085, 7'h05, 4'h2, 16'hE005, 16'h0128);
      $display("tokens done");
   endtask
   task automatic prio(input logic [7:0] tx, input logic [7:0] rx, input logic [7:0] hp,
         input logic [15:0] exp);
      @(posedge core_clk);
      epTx <= tx;
      epRx <= rx;
      epHp <= hp;
      repeat (2) @(posedge core_clk);
      rdc(OFS_IRQ_EVENT, 16'h801F, exp, "ep pick");
   endtask
   task automatic test_prio();
      prio(8'h24, 8'h00, 8'h20, 16'h8005);
      prio(8'h24, 8'h04, 8'h00, 16'h8012);
      prio(8'h00, 8'h80, 8'h00, 16'h8017);
      prio(8'h81, 8'h00, 8'h00, 16'h8000);
      prio(8'h00, 8'h00, 8'h00, 16'h0000);
      $display("priority done");
   endtask
   // ----------------------------------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      resetn = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWdata = 16'h0000;
      epTx = '0;
      epRx = '0;
      epHp = '0;
      epAddrField = 32'h76543210;
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (5) @(posedge core_clk);
      test_regs();
      test_busreset();
      test_frames();
      test_wake();
      test_tokens();
      test_prio();
      give_verdict();
   end
endmodule
